// ---- core/event_latch.sv ----
// sticky event bits, cleared as a whole, with set winning over clear
`timescale 1ns/1ps
`default_nettype none
module event_latch (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// events and clear
	input wire status_pkg::evt_t set,
	input wire logic clear,
	// latched value
	output var status_pkg::evt_t value
);
	status_pkg::evt_t value_nxt;

	always_comb begin
		value_nxt = clear ? status_pkg::evt_t'(status_pkg::EVT_RESET) : value;
		value_nxt = value_nxt | set;
		// bit 1 has no event source and always reads zero
		value_nxt.spare_event = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			value <= status_pkg::evt_t'(status_pkg::EVT_RESET);
		end else begin
			value <= value_nxt;
		end
	end
endmodule : event_latch
`default_nettype wire

// ---- core/output_queue.sv ----
// first-in first-out response queue with registered read port
`timescale 1ns/1ps
`default_nettype none
module output_queue #(
	parameter int WIDTH = status_pkg::QUEUE_DATA_W,
	parameter int DEPTH = status_pkg::QUEUE_DEPTH_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write side
	input wire logic wr_valid,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic rd_req,
	output var logic rd_valid,
	output var logic [WIDTH-1:0] rd_data,
	// fill state
	output var logic empty,
	output var logic full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic do_wr;
	logic do_rd;

	assign empty = (count_r == '0);
	assign full = (count_r == CW'(DEPTH));
	assign do_rd = rd_req && !empty;
	// a write into a full queue is lost unless a read frees a slot that cycle
	assign do_wr = wr_valid && (!full || do_rd);

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr_r] <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_r <= bump(wr_ptr_r);
			end
			if (do_rd) begin
				rd_ptr_r <= bump(rd_ptr_r);
			end
			count_r <= count_r + CW'(do_wr) - CW'(do_rd);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			rd_valid <= do_rd;
			if (do_rd) begin
				rd_data <= mem[rd_ptr_r];
			end
		end
	end
endmodule : output_queue
`default_nettype wire

// ---- core/status_pkg.sv ----
// shared constants and carrier types for the status reporting registers
package status_pkg;
	localparam int MASK_W = 8;
	localparam int EVT_W = 8;
	localparam int LATCH_W = 16;
	localparam int VALUE_W = 16;
	localparam int STB_W = 8;
	localparam int QUEUE_DATA_W = 8;
	localparam int QUEUE_DEPTH_DEF = 16;
	localparam logic [VALUE_W-1:0] SRQ_MASK_MAX = 16'h00bf;
	localparam logic [VALUE_W-1:0] EVT_MASK_MAX = 16'h00ff;
	localparam int SRQ_UNUSED_BIT = 6;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MSS_BIT = 6;
	localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;
	localparam logic [EVT_W-1:0] EVT_RESET = 8'h00;
	localparam logic [STB_W-1:0] STB_RESET = 8'h00;
	localparam logic [LATCH_W-EVT_W-1:0] LATCH_HIGH = 8'h00;

	typedef enum logic [2:0] {
		CMD_WR_SRQ_MASK,
		CMD_RD_SRQ_MASK,
		CMD_WR_EVT_MASK,
		CMD_RD_EVT_MASK,
		CMD_RD_EVENTS,
		CMD_RD_STATUS,
		CMD_CLEAR_STATUS,
		CMD_OP_COMPLETE
	} cmd_t;

	typedef struct packed {
		logic valid;
		cmd_t code;
		logic [VALUE_W-1:0] value;
	} cmd_req_t;

	typedef struct packed {
		logic valid;
		logic [VALUE_W-1:0] data;
	} rsp_t;

	// field order matches event bits 7 down to 0
	typedef struct packed {
		logic power_up_event;
		logic adapter_change_event;
		logic command_syntax_error;
		logic run_refused_error;
		logic device_fault_error;
		logic queue_read_error;
		logic spare_event;
		logic operation_done_event;
	} evt_t;
endpackage : status_pkg

// ---- core/status_reporting_registers.sv ----
// status byte, service request and event masks, event latch and output queue
//
// Notes on behaviour
// - 8-bit service request mask enables status byte summaries toward service request.
// - service request mask reads back as a value, bit 6 always zero.
// - writing zero clears the mask; a clear mask never raises service request.
// - service request mask is zero after power-on.
// - event latch is sixteen bits, upper byte always zero.
// - event latch holds only the power-up bit 7 just after power-on and clears on every read.
// - bit 6 records any adapter plugged into or pulled from the front connector.
// - bit 5 records a malformed command or query.
// - bit 4 records a command refused by state or out-of-range parameter.
// - bit 3 records a device operation that failed, such as overload.
// - bit 2 records a queue read with nothing waiting, or lost queue data.
// - bit 0 records completion of pending operations after operation-complete command.
// - 8-bit event mask picks which latched events feed the event summary.
// - event mask is written by command, read back as value, zero clears it.
// - event mask is zero after power-on.
// - responses wait in a first-in first-out queue until read.
// - message-waiting summary tells whether the queue holds data.
// - output queue is empty after power-on.
// - status bit 5 follows any latched event that is also enabled.
// - status bit 4 is one while the queue holds data.
// - status bit 6 is one while an enabled summary bit is one.
`timescale 1ns/1ps
`default_nettype none
module status_reporting_registers #(
	parameter int QUEUE_DEPTH = status_pkg::QUEUE_DEPTH_DEF,
	parameter int DATA_W = status_pkg::QUEUE_DATA_W
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// common command port and its answer
	input wire status_pkg::cmd_req_t CMD,
	output var status_pkg::rsp_t RSP,
	// event sources on this clock
	input wire logic SYNTAX_ERR,
	input wire logic RUN_REFUSED,
	input wire logic DEVICE_FAULT,
	input wire logic OPS_BUSY,
	// front connector adapter sense pin
	input wire logic ADAPTER_SENSE,
	// output queue
	input wire logic Q_WR_VALID,
	input wire logic [DATA_W-1:0] Q_WR_DATA,
	input wire logic Q_RD_REQ,
	input wire logic RESP_PENDING,
	output var logic Q_RD_VALID,
	output var logic [DATA_W-1:0] Q_RD_DATA,
	// summaries
	output var logic [status_pkg::STB_W-1:0] STATUS_BYTE,
	output var logic SERVICE_REQ
);
	logic [status_pkg::MASK_W-1:0] srq_mask_r;
	logic [status_pkg::MASK_W-1:0] evt_mask_r;
	status_pkg::evt_t evt_r;
	status_pkg::evt_t evt_set;
	logic evt_clear;
	logic pon_pending_r;
	logic opc_armed_r;
	logic sense_q1;
	logic sense_q2;
	logic sense_q3;
	logic adapter_edge;
	logic q_empty;
	logic q_full;
	logic q_rd_err;
	logic q_lost;
	logic wr_srq;
	logic wr_evt;
	logic srq_bad;
	logic evt_bad;
	logic esb_nxt;
	logic mav_nxt;
	logic mss_nxt;
	logic [status_pkg::STB_W-1:0] stb_nxt;
	logic [status_pkg::VALUE_W-1:0] rsp_nxt;

	function automatic logic is_cmd(input status_pkg::cmd_req_t req, input status_pkg::cmd_t c);
		is_cmd = req.valid && (req.code == c);
	endfunction : is_cmd

	function automatic logic is_read(input status_pkg::cmd_req_t req);
		is_read = req.valid && (req.code inside {status_pkg::CMD_RD_SRQ_MASK,
			status_pkg::CMD_RD_EVT_MASK, status_pkg::CMD_RD_EVENTS,
			status_pkg::CMD_RD_STATUS});
	endfunction : is_read

	// mask writes
	assign wr_srq = is_cmd(CMD, status_pkg::CMD_WR_SRQ_MASK);
	assign wr_evt = is_cmd(CMD, status_pkg::CMD_WR_EVT_MASK);
	assign srq_bad = wr_srq && (CMD.value > status_pkg::SRQ_MASK_MAX);
	assign evt_bad = wr_evt && (CMD.value > status_pkg::EVT_MASK_MAX);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			srq_mask_r <= status_pkg::MASK_RESET;
		end else if (wr_srq && !srq_bad) begin
			srq_mask_r <= CMD.value[status_pkg::MASK_W-1:0];
			// values 64..127 are in range but the unused bit is never stored
			srq_mask_r[status_pkg::SRQ_UNUSED_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			evt_mask_r <= status_pkg::MASK_RESET;
		end else if (wr_evt && !evt_bad) begin
			evt_mask_r <= CMD.value[status_pkg::MASK_W-1:0];
		end
	end

	// adapter pin synchroniser; only the second and third stages feed logic
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sense_q1 <= 1'b0;
			sense_q2 <= 1'b0;
			sense_q3 <= 1'b0;
		end else begin
			sense_q1 <= ADAPTER_SENSE;
			sense_q2 <= sense_q1;
			sense_q3 <= sense_q2;
		end
	end
	// a pin already high at reset release reports as a connect event
	assign adapter_edge = sense_q2 ^ sense_q3;

	// power-on marker: held through reset, fires once just after release
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pon_pending_r <= 1'b1;
		end else begin
			pon_pending_r <= 1'b0;
		end
	end

	// operation-complete waits until the execution engine reports idle
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			opc_armed_r <= 1'b0;
		end else if (is_cmd(CMD, status_pkg::CMD_OP_COMPLETE)) begin
			opc_armed_r <= 1'b1;
		end else if (opc_armed_r && !OPS_BUSY) begin
			opc_armed_r <= 1'b0;
		end else if (is_cmd(CMD, status_pkg::CMD_CLEAR_STATUS)) begin
			opc_armed_r <= 1'b0;
		end
	end

	// queue errors
	assign q_rd_err = Q_RD_REQ && q_empty && !RESP_PENDING;
	assign q_lost = Q_WR_VALID && q_full && !Q_RD_REQ;

	always_comb begin
		evt_set = status_pkg::evt_t'(status_pkg::EVT_RESET);
		evt_set.power_up_event = pon_pending_r;
		evt_set.adapter_change_event = adapter_edge;
		evt_set.command_syntax_error = SYNTAX_ERR;
		evt_set.run_refused_error = RUN_REFUSED || srq_bad || evt_bad;
		evt_set.device_fault_error = DEVICE_FAULT;
		evt_set.queue_read_error = q_rd_err || q_lost;
		evt_set.operation_done_event = opc_armed_r && !OPS_BUSY;
	end

	assign evt_clear = is_cmd(CMD, status_pkg::CMD_RD_EVENTS)
		|| is_cmd(CMD, status_pkg::CMD_CLEAR_STATUS);

	event_latch u_events (
		.clk(CLOCK),
		.rst(RST),
		.set(evt_set),
		.clear(evt_clear),
		.value(evt_r)
	);

	output_queue #(
		.WIDTH(DATA_W),
		.DEPTH(QUEUE_DEPTH)
	) u_queue (
		.clk(CLOCK),
		.rst(RST),
		.wr_valid(Q_WR_VALID),
		.wr_data(Q_WR_DATA),
		.rd_req(Q_RD_REQ),
		.rd_valid(Q_RD_VALID),
		.rd_data(Q_RD_DATA),
		.empty(q_empty),
		.full(q_full)
	);

	// summaries are recomputed every cycle and never latch
	always_comb begin
		esb_nxt = |(evt_r & evt_mask_r);
		mav_nxt = !q_empty;
		stb_nxt = status_pkg::STB_RESET;
		stb_nxt[status_pkg::STB_ESB_BIT] = esb_nxt;
		stb_nxt[status_pkg::STB_MAV_BIT] = mav_nxt;
		mss_nxt = |(stb_nxt & srq_mask_r);
		stb_nxt[status_pkg::STB_MSS_BIT] = mss_nxt;
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			STATUS_BYTE <= status_pkg::STB_RESET;
			SERVICE_REQ <= 1'b0;
		end else begin
			STATUS_BYTE <= stb_nxt;
			SERVICE_REQ <= mss_nxt;
		end
	end

	// read answers carry the value seen before any clear in the same cycle
	always_comb begin
		rsp_nxt = '0;
		if (CMD.valid) begin
			unique case (CMD.code)
				status_pkg::CMD_RD_SRQ_MASK: rsp_nxt = {8'h00, srq_mask_r};
				status_pkg::CMD_RD_EVT_MASK: rsp_nxt = {8'h00, evt_mask_r};
				status_pkg::CMD_RD_EVENTS: rsp_nxt = {status_pkg::LATCH_HIGH, evt_r};
				status_pkg::CMD_RD_STATUS: rsp_nxt = {8'h00, STATUS_BYTE};
				status_pkg::CMD_WR_SRQ_MASK,
				status_pkg::CMD_WR_EVT_MASK,
				status_pkg::CMD_CLEAR_STATUS,
				status_pkg::CMD_OP_COMPLETE: rsp_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			RSP <= '0;
		end else begin
			RSP.valid <= is_read(CMD);
			RSP.data <= rsp_nxt;
		end
	end

	// checks
	property p_srq_range;
		@(posedge CLOCK) disable iff (RST)
		srq_bad |=> (srq_mask_r == $past(srq_mask_r)) && evt_r.run_refused_error;
	endproperty
	a_srq_range: assert property (p_srq_range)
		else $error("out-of-range mask write was not refused");

	property p_srq_read;
		@(posedge CLOCK) disable iff (RST)
		is_cmd(CMD, status_pkg::CMD_RD_SRQ_MASK) |=> RSP.valid
			&& (RSP.data == {8'h00, $past(srq_mask_r)})
			&& !RSP.data[status_pkg::SRQ_UNUSED_BIT];
	endproperty
	a_srq_read: assert property (p_srq_read)
		else $error("service mask readback wrong");

	property p_srq_zero;
		@(posedge CLOCK) disable iff (RST)
		(srq_mask_r == status_pkg::MASK_RESET) |=> !SERVICE_REQ
			&& !STATUS_BYTE[status_pkg::STB_MSS_BIT];
	endproperty
	a_srq_zero: assert property (p_srq_zero)
		else $error("service request raised with clear mask");

	property p_events_read;
		@(posedge CLOCK) disable iff (RST)
		is_cmd(CMD, status_pkg::CMD_RD_EVENTS) |=> RSP.valid
			&& (RSP.data == {status_pkg::LATCH_HIGH, $past(evt_r)})
			&& (evt_r == ($past(evt_set) & ~status_pkg::evt_t'(8'h02)));
	endproperty
	a_events_read: assert property (p_events_read)
		else $error("event read did not return and clear the latch");

	property p_pon;
		@(posedge CLOCK) disable iff (RST)
		pon_pending_r |=> evt_r.power_up_event ##1 !pon_pending_r;
	endproperty
	a_pon: assert property (p_pon)
		else $error("power-up event missing");

	property p_adapter;
		@(posedge CLOCK) disable iff (RST)
		$changed(sense_q2) |-> adapter_edge ##1 evt_r.adapter_change_event;
	endproperty
	a_adapter: assert property (p_adapter)
		else $error("adapter change not latched");

	property p_opc;
		@(posedge CLOCK) disable iff (RST)
		(opc_armed_r && !OPS_BUSY) |=> evt_r.operation_done_event && !opc_armed_r;
	endproperty
	a_opc: assert property (p_opc)
		else $error("operation complete not reported");

	property p_queue_err;
		@(posedge CLOCK) disable iff (RST)
		(Q_RD_REQ && q_empty && !RESP_PENDING) |=> evt_r.queue_read_error && !Q_RD_VALID;
	endproperty
	a_queue_err: assert property (p_queue_err)
		else $error("empty queue read not flagged");

	property p_evt_write;
		@(posedge CLOCK) disable iff (RST)
		(wr_evt && !evt_bad) |=> evt_mask_r == $past(CMD.value[status_pkg::MASK_W-1:0]);
	endproperty
	a_evt_write: assert property (p_evt_write)
		else $error("event mask write lost");

	property p_esb;
		@(posedge CLOCK) disable iff (RST)
		1'b1 |=> STATUS_BYTE[status_pkg::STB_ESB_BIT] == |($past(evt_r) & $past(evt_mask_r));
	endproperty
	a_esb: assert property (p_esb)
		else $error("event summary bit wrong");

	property p_mav;
		@(posedge CLOCK) disable iff (RST)
		Q_WR_VALID && q_empty && !Q_RD_REQ |=> ##1 STATUS_BYTE[status_pkg::STB_MAV_BIT];
	endproperty
	a_mav: assert property (p_mav)
		else $error("message waiting bit not set after queue write");

	property p_mss;
		@(posedge CLOCK) disable iff (RST)
		1'b1 |=> SERVICE_REQ == STATUS_BYTE[status_pkg::STB_MSS_BIT]
			&& (SERVICE_REQ == |($past(stb_nxt) & $past(srq_mask_r)
				& ~(8'h01 << status_pkg::STB_MSS_BIT)));
	endproperty
	a_mss: assert property (p_mss)
		else $error("master summary wrong");
endmodule : status_reporting_registers
`default_nettype wire

// ---- tb/bus_controller.sv ----
// remote controller model that issues common commands and captures answers
`timescale 1ns/1ps
`default_nettype none
module bus_controller (
	// clock
	input wire logic clk,
	// command port toward the device
	output var status_pkg::cmd_req_t cmd,
	input wire status_pkg::rsp_t rsp
);
	initial cmd = '0;

	// one-cycle valid pulse launched at the falling edge
	task automatic issue(input status_pkg::cmd_t code, input logic [15:0] value);
		@(negedge clk);
		cmd.valid = 1'b1;
		cmd.code = code;
		cmd.value = value;
		@(negedge clk);
		cmd.valid = 1'b0;
		// value no longer qualified, so it must not look stable
		cmd.value = ~value;
	endtask : issue

	// a real controller never exceeds the range; bad asks for a deliberate breach
	task automatic set_srq(input logic [15:0] value, input bit bad);
		if (value > 16'h00bf && !bad) begin
			value = 16'h00bf;
		end
		issue(status_pkg::CMD_WR_SRQ_MASK, value);
	endtask : set_srq

	task automatic query(input status_pkg::cmd_t code, output logic [15:0] data,
			output logic ok);
		issue(code, 16'h0000);
		// the answer stands only from the taking edge to the next, so look mid-cycle
		ok = rsp.valid;
		data = rsp.data;
	endtask : query
endmodule : bus_controller
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the status reporting registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int DEPTH = 4;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ev = 4'h0;
	logic adapter = 1'b0;
	logic q_wr = 1'b0;
	logic [7:0] q_data = 8'h00;
	logic q_rd = 1'b0;
	logic pending = 1'b0;
	status_pkg::cmd_req_t cmd;
	status_pkg::rsp_t rsp;
	logic q_valid;
	logic [7:0] q_out;
	logic [7:0] stb;
	logic srq;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [15:0] d;
	logic ok;
	logic v;
	logic [7:0] b;
	logic [15:0] evt_bit [3] = '{16'h0020, 16'h0010, 16'h0008};

	always #20 clock = ~clock;

	bus_controller ctl (
		.clk(clock),
		.cmd(cmd),
		.rsp(rsp)
	);

	status_reporting_registers #(.QUEUE_DEPTH(DEPTH), .DATA_W(8)) dut (
		.CLOCK(clock),
		.RST(rst),
		.CMD(cmd),
		.RSP(rsp),
		.SYNTAX_ERR(ev[0]),
		.RUN_REFUSED(ev[1]),
		.DEVICE_FAULT(ev[2]),
		.OPS_BUSY(ev[3]),
		.ADAPTER_SENSE(adapter),
		.Q_WR_VALID(q_wr),
		.Q_WR_DATA(q_data),
		.Q_RD_REQ(q_rd),
		.RESP_PENDING(pending),
		.Q_RD_VALID(q_valid),
		.Q_RD_DATA(q_out),
		.STATUS_BYTE(stb),
		.SERVICE_REQ(srq)
	);

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	// whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			conclude();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_n(input int n);
		repeat (n) @(negedge clock);
	endtask : wait_n

	task automatic rd(input status_pkg::cmd_t code, input logic [15:0] exp, input string what);
		ctl.query(code, d, ok);
		check("answer valid", {15'h0000, ok}, 16'h0001);
		check(what, d, exp);
	endtask : rd

	task automatic pulse(input int i);
		@(negedge clock);
		ev[i] = 1'b1;
		@(negedge clock);
		ev[i] = 1'b0;
	endtask : pulse

	task automatic pop();
		@(negedge clock);
		q_rd = 1'b1;
		@(negedge clock);
		q_rd = 1'b0;
		// read strobe stands for one cycle after the pop edge
		v = q_valid;
		b = q_out;
	endtask : pop

	task automatic summ(input logic [7:0] exp_stb, input logic exp_srq);
		check("status byte", {8'h00, stb}, {8'h00, exp_stb});
		check("service request", {15'h0000, srq}, {15'h0000, exp_srq});
	endtask : summ

	initial begin
		wait_n(4);
		rst = 1'b0;
		wait_n(1);
		summ(8'h00, 1'b0);
		rd(status_pkg::CMD_RD_SRQ_MASK, 16'h0000, "service mask");
		rd(status_pkg::CMD_RD_EVT_MASK, 16'h0000, "event mask");
		rd(status_pkg::CMD_RD_EVENTS, 16'h0080, "event latch");
		rd(status_pkg::CMD_RD_EVENTS, 16'h0000, "event latch");
		$display("reset test done");

		ctl.set_srq(16'h00bf, 1'b0);
		rd(status_pkg::CMD_RD_SRQ_MASK, 16'h00bf, "service mask");
		ctl.set_srq(16'h007f, 1'b0);
		rd(status_pkg::CMD_RD_SRQ_MASK, 16'h003f, "service mask");
		ctl.set_srq(16'h00c8, 1'b1);
		rd(status_pkg::CMD_RD_SRQ_MASK, 16'h003f, "service mask");
		rd(status_pkg::CMD_RD_EVENTS, 16'h0010, "event latch");
		ctl.issue(status_pkg::CMD_WR_EVT_MASK, 16'h00ff);
		rd(status_pkg::CMD_RD_EVT_MASK, 16'h00ff, "event mask");
		ctl.issue(status_pkg::CMD_WR_EVT_MASK, 16'h0100);
		rd(status_pkg::CMD_RD_EVT_MASK, 16'h00ff, "event mask");
		rd(status_pkg::CMD_RD_EVENTS, 16'h0010, "event latch");
		ctl.issue(status_pkg::CMD_WR_EVT_MASK, 16'h0000);
		rd(status_pkg::CMD_RD_EVT_MASK, 16'h0000, "event mask");
		ctl.set_srq(16'h0000, 1'b0);
		rd(status_pkg::CMD_RD_SRQ_MASK, 16'h0000, "service mask");
		$display("mask test done");

		for (int i = 0; i < 3; i++) begin
			pulse(i);
			rd(status_pkg::CMD_RD_EVENTS, evt_bit[i], "event latch");
		end
		adapter = 1'b1;
		wait_n(6);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0040, "event latch");
		adapter = 1'b0;
		wait_n(6);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0040, "event latch");
		ev[3] = 1'b1;
		ctl.issue(status_pkg::CMD_OP_COMPLETE, 16'h0000);
		wait_n(3);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0000, "event latch");
		ev[3] = 1'b0;
		wait_n(3);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0001, "event latch");
		pulse(0);
		ctl.issue(status_pkg::CMD_CLEAR_STATUS, 16'h0000);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0000, "event latch");
		$display("event test done");

		ctl.issue(status_pkg::CMD_WR_EVT_MASK, 16'h0020);
		ctl.set_srq(16'h0020, 1'b0);
		pulse(0);
		wait_n(3);
		summ(8'h60, 1'b1);
		rd(status_pkg::CMD_RD_STATUS, 16'h0060, "status read");
		rd(status_pkg::CMD_RD_EVENTS, 16'h0020, "event latch");
		wait_n(3);
		summ(8'h00, 1'b0);
		ctl.set_srq(16'h0000, 1'b0);
		pulse(0);
		wait_n(3);
		summ(8'h20, 1'b0);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0020, "event latch");
		ctl.issue(status_pkg::CMD_WR_EVT_MASK, 16'h0000);
		$display("summary test done");

		ctl.set_srq(16'h0010, 1'b0);
		// one more byte than the queue holds, the last is lost
		for (int i = 0; i <= DEPTH; i++) begin
			@(negedge clock);
			q_wr = 1'b1;
			q_data = 8'h10 + 8'(i);
		end
		@(negedge clock);
		q_wr = 1'b0;
		q_data = 8'hff;
		wait_n(2);
		summ(8'h50, 1'b1);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0004, "event latch");
		for (int i = 0; i < DEPTH; i++) begin
			pop();
			check("queue valid", {15'h0000, v}, 16'h0001);
			check("queue data", {8'h00, b}, 16'h0010 + 16'(i));
		end
		wait_n(3);
		summ(8'h00, 1'b0);
		pending = 1'b1;
		pop();
		check("queue valid", {15'h0000, v}, 16'h0000);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0000, "event latch");
		pending = 1'b0;
		pop();
		check("queue valid", {15'h0000, v}, 16'h0000);
		rd(status_pkg::CMD_RD_EVENTS, 16'h0004, "event latch");
		$display("queue test done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
